// >>> pwct_timer.sv
// Function
// - the measurement behaviour runs only while the mode field holds code 110.
// - writing the count enable bit to one starts the 16-bit counter on the chosen count clock.
// - a valid trigger edge copies the counter into that channel's capture register and clears it.
// - every capture-and-clear raises the capture interrupt of the channel that saw the edge.
// - a count clock at FFFFH with no edge raises the overflow interrupt and wraps to 0000H, except the first one after enable, which only loads 0000H.
// - the wrap sets the overflow flag, which stays set until software clears it.
// - the flag clears by a bit clear, by a byte write of option register 0 with bit 0 low, or while count enable is 0.
// - a trigger right after enable may capture FFFFH instead of 0000H.
// - reading the counter read buffer returns the live counter value, or 0000H while the counter is stopped.
// - output control register 0 is ignored and the timer outputs are held at 0.
module pwct_timer (
   // clock and reset
   input  wire logic                         clk_i,
   input  wire logic                         srst_i,
   // apb slave
   input  wire logic                         psel_i,
   input  wire logic                         penable_i,
   input  wire logic                         pwrite_i,
   input  wire logic [pwct_pkg::ADDR_W-1:0]  paddr_i,
   input  wire logic [pwct_pkg::DATA_W-1:0]  pwdata_i,
   input  wire logic [3:0]                   pstrb_i,
   output logic      [pwct_pkg::DATA_W-1:0]  prdata_o,
   output logic                              pready_o,
   output logic                              pslverr_o,
   // capture trigger pins, pin zero doubles as event input
   input  wire logic [pwct_pkg::CHAN_N-1:0]  capture_trigger_input_i,
   // interrupt requests
   output logic      [pwct_pkg::CHAN_N-1:0]  capture_interrupt_o,
   output logic                              overflow_interrupt_o,
   // timer outputs
   output logic      [pwct_pkg::CHAN_N-1:0]  timer_out_o
);
   import pwct_pkg::*;

   // ==========================================================
   // register decode
   function automatic logic reg_known(input logic [ADDR_W-1:0] a);
      case (a)
         OFS_CTL0, OFS_CTL1, OFS_OUTCTL0, OFS_EDGE, OFS_OPT0,
         OFS_OVFCLR, OFS_CNT, OFS_CAP0, OFS_CAP1: reg_known = 1'b1;
         default:                                 reg_known = 1'b0;
      endcase
   endfunction

   pwct_ctl0_type          ctl0;
   pwct_ctl1_type          ctl1;
   logic [7:0]             outctl0;
   pwct_edge_cfg_type      edge_cfg;
   logic                   ovf_flag;
   pwct_ctl0_type          next_ctl0;
   pwct_ctl1_type          next_ctl1;
   logic [7:0]             next_outctl0;
   pwct_edge_cfg_type      next_edge_cfg;
   logic                   next_ovf_flag;
   logic [DATA_W-1:0]      next_prdata;
   logic                   next_pready;
   logic                   next_pslverr;
   logic                   wr_fire;
   logic                   rd_ask;
   logic                   sw_clr;
   logic [7:0]             wbyte;

   pwct_state_type         state;
   pwct_state_type         next_state;
   logic [CNT_W-1:0]       cnt;
   logic [CNT_W-1:0]       next_cnt;
   logic [CNT_W-1:0]       cap [CHAN_N];
   logic [CNT_W-1:0]       next_cap [CHAN_N];
   logic [CHAN_N-1:0]      next_cap_irq;
   logic                   next_ovf_irq;
   logic [CHAN_N-1:0]      next_tout;
   logic                   ovf_set;
   logic                   run;
   logic                   tick;
   logic                   pre_tick;
   logic [CHAN_N:0]        edges;
   logic [CHAN_N-1:0]      hit;
   pwct_edge_type          edge_sel [CHAN_N+1];

   assign run   = ctl0.ce && (ctl1.md == MODE_PULSE_W);
   assign wbyte = pwdata_i[7:0];

   // ==========================================================
   // edge detectors and count clock
   assign edge_sel[0] = edge_cfg.t0;
   assign edge_sel[1] = edge_cfg.t1;
   assign edge_sel[2] = edge_cfg.evt;

   // the event input sits on trigger zero's pin, so both look at the same wire
   genvar g;
   generate
      for (g = 0; g <= CHAN_N; g++) begin : g_edge
         pwct_edge_det u_edge (
            .clk_i  (clk_i),
            .srst_i (srst_i),
            .sig_i  (capture_trigger_input_i[(g == CHAN_N) ? 0 : g]),
            .sel_i  (edge_sel[g]),
            .edge_o (edges[g])
         );
      end
   endgenerate

   pwct_prescale #(
      .DIV_W (DIV_W)
   ) u_prescale (
      .clk_i  (clk_i),
      .srst_i (srst_i),
      .run_i  (run),
      .cks_i  (ctl0.cks),
      .tick_o (pre_tick)
   );

   assign tick = run && (ctl1.eee ? edges[CHAN_N] : pre_tick);
   assign hit  = (run && (state != CNT_STOP)) ? edges[CHAN_N-1:0] : '0;

   // ==========================================================
   // counter and capture
   always_comb begin
      next_state   = state;
      next_cnt     = cnt;
      next_cap     = cap;
      next_cap_irq = '0;
      next_ovf_irq = 1'b0;
      ovf_set      = 1'b0;
      next_tout    = '0;
      for (int i = 0; i < CHAN_N; i++) begin
         if (hit[i]) begin
            next_cap[i]     = cnt;
            next_cap_irq[i] = 1'b1;
         end
      end
      case (state)
         CNT_STOP: begin
            next_cnt = CNT_MAX;
            if (run) begin
               next_state = CNT_ARMED;
            end
         end
         CNT_ARMED: begin
            // still at FFFFH until the first tick, so an early edge captures FFFFH
            if (!run) begin
               next_state = CNT_STOP;
               next_cnt   = CNT_MAX;
            end else if ((|hit) || tick) begin
               next_state = CNT_RUN;
               next_cnt   = CNT_ZERO;
            end
         end
         CNT_RUN: begin
            if (!run) begin
               next_state = CNT_STOP;
               next_cnt   = CNT_MAX;
            end else if (|hit) begin
               next_cnt = CNT_ZERO;
            end else if (tick) begin
               if (cnt == CNT_MAX) begin
                  next_cnt     = CNT_ZERO;
                  next_ovf_irq = 1'b1;
                  ovf_set      = 1'b1;
               end else begin
                  next_cnt = CNT_W'(cnt + 1'b1);
               end
            end
         end
         default: begin
            next_state = CNT_STOP;
            next_cnt   = CNT_MAX;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         state                <= CNT_STOP;
         cnt                  <= CNT_MAX;
         cap                  <= '{default: CNT_ZERO};
         capture_interrupt_o  <= '0;
         overflow_interrupt_o <= 1'b0;
         timer_out_o          <= '0;
      end else begin
         state                <= next_state;
         cnt                  <= next_cnt;
         cap                  <= next_cap;
         capture_interrupt_o  <= next_cap_irq;
         overflow_interrupt_o <= next_ovf_irq;
         timer_out_o          <= next_tout;
      end
   end

   // ==========================================================
   // apb registers
   always_comb begin
      wr_fire       = psel_i && penable_i && pready_o && pwrite_i && reg_known(paddr_i);
      rd_ask        = psel_i && penable_i && !pready_o;
      next_pready   = rd_ask;
      next_pslverr  = rd_ask && !reg_known(paddr_i);
      next_prdata   = '0;
      next_ctl0     = ctl0;
      next_ctl1     = ctl1;
      next_outctl0  = outctl0;
      next_edge_cfg = edge_cfg;
      sw_clr        = 1'b0;
      if (rd_ask && !pwrite_i) begin
         case (paddr_i)
            OFS_CTL0:    next_prdata[7:0] = {ctl0.ce, 4'h0, ctl0.cks};
            OFS_CTL1:    next_prdata[7:0] = {2'h0, ctl1.eee, 2'h0, ctl1.md};
            OFS_OUTCTL0: next_prdata[7:0] = outctl0;
            OFS_EDGE:    next_prdata[7:0] = {2'h0, edge_cfg};
            OFS_OPT0:    next_prdata[7:0] = {7'h00, ovf_flag};
            OFS_CNT:     next_prdata[15:0] = (state == CNT_STOP) ? CNT_ZERO : cnt;
            OFS_CAP0:    next_prdata[15:0] = cap[0];
            OFS_CAP1:    next_prdata[15:0] = cap[1];
            default:     next_prdata = '0;
         endcase
      end
      if (wr_fire && pstrb_i[0]) begin
         case (paddr_i)
            OFS_CTL0: begin
               next_ctl0.ce  = wbyte[CTL0_CE_BIT];
               next_ctl0.cks = wbyte[CTL0_CKS_LSB +: 3];
            end
            OFS_CTL1: begin
               next_ctl1.eee = wbyte[CTL1_EEE_BIT];
               next_ctl1.md  = wbyte[CTL1_MD_LSB +: 3];
            end
            // stored for readback only, it steers nothing in this mode
            OFS_OUTCTL0: next_outctl0 = wbyte;
            OFS_EDGE: begin
               next_edge_cfg.t0  = pwct_edge_type'(wbyte[EDGE_T0_LSB +: 2]);
               next_edge_cfg.t1  = pwct_edge_type'(wbyte[EDGE_T1_LSB +: 2]);
               next_edge_cfg.evt = pwct_edge_type'(wbyte[EDGE_EVT_LSB +: 2]);
            end
            OFS_OPT0:   sw_clr = !wbyte[OPT0_OVF_BIT];
            OFS_OVFCLR: sw_clr = wbyte[OVFCLR_BIT];
            default:    sw_clr = 1'b0;
         endcase
      end
      // set beats clear, so a wrap in the clearing cycle is kept
      next_ovf_flag = ovf_flag;
      if (sw_clr || !ctl0.ce) begin
         next_ovf_flag = 1'b0;
      end
      if (ovf_set) begin
         next_ovf_flag = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         ctl0      <= pwct_ctl0_type'(RST_BYTE[3:0]);
         ctl1      <= pwct_ctl1_type'(RST_BYTE[3:0]);
         outctl0   <= RST_BYTE;
         edge_cfg  <= pwct_edge_cfg_type'(RST_BYTE[5:0]);
         ovf_flag  <= 1'b0;
         prdata_o  <= '0;
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
      end else begin
         ctl0      <= next_ctl0;
         ctl1      <= next_ctl1;
         outctl0   <= next_outctl0;
         edge_cfg  <= next_edge_cfg;
         ovf_flag  <= next_ovf_flag;
         prdata_o  <= next_prdata;
         pready_o  <= next_pready;
         pslverr_o <= next_pslverr;
      end
   end

   // ==========================================================
   // checks
   // channel one, the only trigger that stays usable with the event clock
   sequence s_capture1;
      run && (state != CNT_STOP) && edges[1];
   endsequence

   sequence s_cleared;
      cnt == CNT_ZERO;
   endsequence

   property p_mode_gate;
      @(posedge clk_i) disable iff (srst_i)
      !run |=> (state == CNT_STOP) && (cnt == CNT_MAX);
   endproperty
   a_mode_gate: assert property (p_mode_gate) else $error("counter active outside mode");

   property p_count_up;
      @(posedge clk_i) disable iff (srst_i)
      (state == CNT_RUN) && run && tick && !(|hit) && (cnt != CNT_MAX)
      |=> cnt == CNT_W'($past(cnt) + 1'b1);
   endproperty
   a_count_up: assert property (p_count_up) else $error("counter did not step by one");

   property p_capture_clear;
      @(posedge clk_i) disable iff (srst_i)
      s_capture1 |=> s_cleared ##0 (cap[1] == $past(cnt));
   endproperty
   a_capture_clear: assert property (p_capture_clear) else $error("capture or clear wrong");

   property p_cap_irq;
      @(posedge clk_i) disable iff (srst_i)
      s_capture1 |=> capture_interrupt_o[1] && (!capture_interrupt_o[0] || $past(hit[0]));
   endproperty
   a_cap_irq: assert property (p_cap_irq) else $error("capture interrupt missing");

   property p_wrap;
      @(posedge clk_i) disable iff (srst_i)
      (state == CNT_RUN) && run && tick && !(|hit) && (cnt == CNT_MAX)
      |=> overflow_interrupt_o ##0 s_cleared ##1 !overflow_interrupt_o;
   endproperty
   a_wrap: assert property (p_wrap) else $error("overflow not raised on wrap");

   property p_flag_sticky;
      @(posedge clk_i) disable iff (srst_i)
      overflow_interrupt_o ##1 !$past(sw_clr) && ctl0.ce |-> ovf_flag;
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("overflow flag lost");

   property p_flag_clear;
      @(posedge clk_i) disable iff (srst_i)
      sw_clr && !ovf_set |=> !ovf_flag;
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("overflow flag not cleared");

   property p_early_capture;
      @(posedge clk_i) disable iff (srst_i)
      (state == CNT_ARMED) && hit[1] |=> (cap[1] == CNT_MAX) && (state == CNT_RUN);
   endproperty
   a_early_capture: assert property (p_early_capture) else $error("early capture wrong");

   property p_cnt_read;
      @(posedge clk_i) disable iff (srst_i)
      rd_ask && !pwrite_i && (paddr_i == OFS_CNT) && (state != CNT_STOP)
      |=> pready_o && (prdata_o[15:0] == $past(cnt));
   endproperty
   a_cnt_read: assert property (p_cnt_read) else $error("counter read wrong");

   property p_no_out;
      @(posedge clk_i) disable iff (srst_i)
      $changed(outctl0) |-> ##[0:2] (timer_out_o == '0);
   endproperty
   a_no_out: assert property (p_no_out) else $error("timer output driven");

   property p_resume;
      @(posedge clk_i) disable iff (srst_i)
      s_capture1 ##1 run && tick && !(|hit) |=> cnt == CNT_ONE;
   endproperty
   a_resume: assert property (p_resume) else $error("count lost after capture");
endmodule

// >>> pwct_pkg.sv
package pwct_pkg;
   // ==========================================================
   // widths
   localparam int           CNT_W          = 16;
   localparam int           ADDR_W         = 8;
   localparam int           DATA_W         = 32;
   localparam int           CHAN_N         = 2;
   localparam int           DIV_W          = 8;
   // ==========================================================
   // register byte offsets
   localparam logic [7:0]   OFS_CTL0       = 8'h00;
   localparam logic [7:0]   OFS_CTL1       = 8'h04;
   localparam logic [7:0]   OFS_OUTCTL0    = 8'h08;
   localparam logic [7:0]   OFS_EDGE       = 8'h0c;
   localparam logic [7:0]   OFS_OPT0       = 8'h10;
   localparam logic [7:0]   OFS_OVFCLR     = 8'h14;
   localparam logic [7:0]   OFS_CNT        = 8'h18;
   localparam logic [7:0]   OFS_CAP0       = 8'h1c;
   localparam logic [7:0]   OFS_CAP1       = 8'h20;
   // ==========================================================
   // field positions
   localparam int           CTL0_CE_BIT    = 7;
   localparam int           CTL0_CKS_LSB   = 0;
   localparam int           CTL1_EEE_BIT   = 5;
   localparam int           CTL1_MD_LSB    = 0;
   localparam int           EDGE_T0_LSB    = 0;
   localparam int           EDGE_T1_LSB    = 2;
   localparam int           EDGE_EVT_LSB   = 4;
   localparam int           OPT0_OVF_BIT   = 0;
   localparam int           OVFCLR_BIT     = 0;
   // ==========================================================
   // reset values and codes
   localparam logic [7:0]   RST_BYTE       = 8'h00;
   localparam logic [2:0]   MODE_PULSE_W   = 3'h6;
   localparam logic [15:0]  CNT_MAX        = 16'hffff;
   localparam logic [15:0]  CNT_ZERO       = 16'h0000;
   localparam logic [15:0]  CNT_ONE        = 16'h0001;
   // ==========================================================
   // types
   typedef enum logic [1:0] {
      EDGE_NONE = 2'h0,
      EDGE_RISE = 2'h1,
      EDGE_FALL = 2'h2,
      EDGE_BOTH = 2'h3
   } pwct_edge_type;

   typedef enum logic [1:0] {
      CNT_STOP  = 2'h0,
      CNT_ARMED = 2'h1,
      CNT_RUN   = 2'h2
   } pwct_state_type;

   typedef struct packed {
      logic       ce;
      logic [2:0] cks;
   } pwct_ctl0_type;

   typedef struct packed {
      logic       eee;
      logic [2:0] md;
   } pwct_ctl1_type;

   typedef struct packed {
      pwct_edge_type evt;
      pwct_edge_type t1;
      pwct_edge_type t0;
   } pwct_edge_cfg_type;
endpackage

// >>> pwct_edge_det.sv
module pwct_edge_det (
   // clock and reset
   input  wire logic                   clk_i,
   input  wire logic                   srst_i,
   // pin and selection
   input  wire logic                   sig_i,
   input  wire pwct_pkg::pwct_edge_type sel_i,
   // detected edge
   output logic                        edge_o
);
   import pwct_pkg::*;

   logic prev;
   logic next_prev;

   always_comb begin
      next_prev = sig_i;
      case (sel_i)
         EDGE_RISE: edge_o = sig_i & ~prev;
         EDGE_FALL: edge_o = ~sig_i & prev;
         EDGE_BOTH: edge_o = sig_i ^ prev;
         default:   edge_o = 1'b0;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         prev <= 1'b0;
      end else begin
         prev <= next_prev;
      end
   end

   property p_edge_none;
      @(posedge clk_i) disable iff (srst_i)
      (sel_i == EDGE_NONE) |-> !edge_o;
   endproperty
   a_edge_none: assert property (p_edge_none) else $error("edge seen with detection off");

   property p_edge_rise;
      @(posedge clk_i) disable iff (srst_i)
      (sel_i == EDGE_RISE) && $rose(sig_i) |-> edge_o;
   endproperty
   a_edge_rise: assert property (p_edge_rise) else $error("rising edge missed");
endmodule

// >>> pwct_prescale.sv
module pwct_prescale #(
   parameter int DIV_W = pwct_pkg::DIV_W
) (
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       srst_i,
   // control
   input  wire logic       run_i,
   input  wire logic [2:0] cks_i,
   // count clock tick
   output logic            tick_o
);
   import pwct_pkg::*;

   logic [DIV_W-1:0] div;
   logic [DIV_W-1:0] next_div;
   logic [DIV_W-1:0] mask;

   // divide by 2 to the power cks plus one
   always_comb begin
      mask     = {DIV_W{1'b1}} >> (3'h7 - cks_i);
      tick_o   = run_i && ((div & mask) == mask);
      next_div = run_i ? DIV_W'(div + 1'b1) : '0;
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         div <= '0;
      end else begin
         div <= next_div;
      end
   end

   property p_tick_fast;
      @(posedge clk_i) disable iff (srst_i)
      tick_o && run_i && (cks_i == 3'h0) ##1 run_i && (cks_i == 3'h0) |-> !tick_o;
   endproperty
   a_tick_fast: assert property (p_tick_fast) else $error("divide by two ticks twice in a row");
endmodule

// >>> pwct_pulse_src.sv
module pwct_pulse_src (
   // clock
   input  wire logic        clk_i,
   // commands from the bench
   input  wire logic        ev_go_i,
   input  wire logic [16:0] ev_n_i,
   input  wire logic        tr_go_i,
   // pins toward the timer
   output logic      [1:0]  pin_o,
   output logic             busy_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [16:0] left;
   logic [1:0]  tr_cnt;
   initial begin
      pin_o  = 2'h0;
      left   = 17'h0;
      tr_cnt = 2'h0;
   end
   // ==========================================================
   // event train on pin zero, one toggle a cycle so each cycle ticks
   always @(posedge clk_i) begin
      if (ev_go_i) begin
         left <= ev_n_i;
      end else if (left != 17'h0) begin
         pin_o[0] <= ~pin_o[0];
         left     <= left - 17'h1;
      end
   end
   // ==========================================================
   // triggers only on pin one, pin zero stays the event clock
   always @(posedge clk_i) begin
      if (tr_go_i) begin
         pin_o[1] <= 1'b1;
         tr_cnt   <= 2'h2;
      end else if (tr_cnt != 2'h0) begin
         tr_cnt <= tr_cnt - 2'h1;
         if (tr_cnt == 2'h1) begin
            pin_o[1] <= 1'b0;
         end
      end
   end
   assign busy_o = (left != 17'h0) || (tr_cnt != 2'h0);
endmodule

// >>> pwct_timer_bench.sv
module pwct_timer_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import pwct_pkg::*;
   logic              clk;
   logic              srst;
   logic              psel;
   logic              penable;
   logic              pwrite;
   logic [ADDR_W-1:0] paddr;
   logic [31:0]       pwdata;
   logic [3:0]        pstrb;
   logic [31:0]       prdata;
   logic              pready;
   logic              pslverr;
   logic [1:0]        cap_irq;
   logic              ovf_irq;
   logic [1:0]        tout;
   logic [1:0]        pins;
   logic              ev_go;
   logic [16:0]       ev_n;
   logic              tr_go;
   logic              src_busy;
   int                fails       = 0;
   int                check_count = 0;
   int                irq0_n      = 0;
   int                irq1_n      = 0;
   int                ovf_n       = 0;

   pwct_timer uut (.clk_i(clk), .srst_i(srst), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .capture_trigger_input_i(pins), .capture_interrupt_o(cap_irq),
      .overflow_interrupt_o(ovf_irq), .timer_out_o(tout));
   pwct_pulse_src src (.clk_i(clk), .ev_go_i(ev_go), .ev_n_i(ev_n), .tr_go_i(tr_go),
      .pin_o(pins), .busy_o(src_busy));

   always #25 clk = ~clk;
   // ==========================================================
   // interrupt pulse counters
   always @(posedge clk) begin
      if (cap_irq[0] === 1'b1) irq0_n++;
      if (cap_irq[1] === 1'b1) irq1_n++;
      if (ovf_irq === 1'b1) ovf_n++;
   end
   // ==========================================================
   // helpers
   task chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] rd, output logic err);
      int n;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      pstrb   <= 4'h1;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      if (n >= 20) fails++;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask
   task rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      chk(r, exp);
   endtask
   // one tick per toggle, since the event edge select takes both edges
   task toggles(input logic [16:0] n);
      int k;
      @(posedge clk);
      ev_go <= 1'b1;
      ev_n  <= n;
      @(posedge clk);
      ev_go <= 1'b0;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (src_busy && k < 70000);
      repeat (3) @(posedge clk);
   endtask
   task trig;
      @(posedge clk);
      tr_go <= 1'b1;
      @(posedge clk);
      tr_go <= 1'b0;
      repeat (6) @(posedge clk);
   endtask
   task report_and_stop;
      $display("checks=%0d mismatches=%0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // ==========================================================
   // scenarios
   task t_reset;
      logic [31:0] r;
      logic        e;
      rd_chk(OFS_CTL0, 32'h0);
      rd_chk(OFS_OPT0, 32'h0);
      rd_chk(OFS_CNT, 32'h0);
      rd_chk(OFS_CAP1, 32'h0);
      apb(1'b0, 8'h30, 32'h0, r, e);
      chk({31'h0, e}, 32'h1);
      wr(OFS_OUTCTL0, 32'hff);
      rd_chk(OFS_OUTCTL0, 32'hff);
      chk({30'h0, tout}, 32'h0);
      $display("test reset done");
   endtask
   task t_mode;
      wr(OFS_EDGE, 32'h34);
      wr(OFS_CTL1, 32'h25);
      wr(OFS_CTL0, 32'h80);
      trig;
      chk(irq1_n, 1'b0);
      rd_chk(OFS_CAP1, 32'h0);
      // mode bits only change while stopped, running rewrites are unguarded
      wr(OFS_CTL0, 32'h0);
      wr(OFS_CTL1, 32'h26);
      wr(OFS_CTL0, 32'h80);
      $display("test mode done");
   endtask
   task t_capture;
      trig;
      chk(irq1_n, 32'h1);
      rd_chk(OFS_CAP1, 32'hffff);
      rd_chk(OFS_CNT, 32'h0);
      toggles(17'd37);
      rd_chk(OFS_CNT, 32'd37);
      trig;
      chk(irq1_n, 32'h2);
      chk(irq0_n, 32'h0);
      rd_chk(OFS_CAP1, 32'd37);
      rd_chk(OFS_CAP0, 32'h0);
      rd_chk(OFS_CNT, 32'h0);
      toggles(17'd5);
      rd_chk(OFS_CNT, 32'd5);
      $display("test capture done");
   endtask
   task t_overflow;
      logic [31:0] r;
      logic        e;
      toggles(17'd65530);
      chk(ovf_n, 32'h0);
      rd_chk(OFS_CNT, 32'hffff);
      toggles(17'd1);
      chk(ovf_n, 32'h1);
      rd_chk(OFS_CNT, 32'h0);
      rd_chk(OFS_OPT0, 32'h1);
      wr(OFS_OPT0, 32'h1);
      rd_chk(OFS_OPT0, 32'h1);
      wr(OFS_OPT0, 32'h0);
      rd_chk(OFS_OPT0, 32'h0);
      chk({30'h0, tout}, 32'h0);
      // width since the last capture: 5 + 65530 + 1 + 3 ticks
      toggles(17'd3);
      trig;
      apb(1'b0, OFS_CAP1, 32'h0, r, e);
      chk(r + 32'h10000 * ovf_n, 32'd65539);
      $display("test overflow done");
   endtask
   // internal clock, divide by 256: first tick 256 cycles after enable
   task t_prescale;
      wr(OFS_CTL0, 32'h0);
      wr(OFS_CTL1, 32'h6);
      wr(OFS_CTL0, 32'h87);
      rd_chk(OFS_CNT, 32'hffff);
      repeat (300) @(posedge clk);
      rd_chk(OFS_CNT, 32'h0);
      repeat (256) @(posedge clk);
      rd_chk(OFS_CNT, 32'h1);
      $display("test prescale done");
   endtask
   // ==========================================================
   // main sequence and watchdog
   initial begin
      clk     = 1'b0;
      srst    = 1'b1;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = '0;
      pwdata  = 32'h0;
      pstrb   = 4'h0;
      ev_go   = 1'b0;
      ev_n    = 17'h0;
      tr_go   = 1'b0;
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      t_reset;
      t_mode;
      t_capture;
      t_overflow;
      t_prescale;
      report_and_stop;
   end
   // the overflow run alone needs about 66k cycles
   initial begin
      #4500000;
      fails++;
      report_and_stop;
   end
endmodule
